//--- src/dpf_map.svh
// register map, frame fields and timing constants of the power and fault block
// assumes: included by bare name from every design file that decodes frames
`ifndef DPF_MAP_SVH
`define DPF_MAP_SVH

`define DPF_FRAME_BITS  5'd24
`define DPF_FRAME_LAST  5'd23
`define DPF_RB_LOAD_AT  5'd2
`define DPF_BIT_RW      23
`define DPF_BIT_ZERO    22
`define DPF_REG_HI      21
`define DPF_REG_LO      19
`define DPF_ADR_HI      18
`define DPF_ADR_LO      16
`define DPF_DATA_HI     15
`define DPF_RANGE_HI    2
`define DPF_REG_DAC     3'h0
`define DPF_REG_RANGE   3'h1
`define DPF_REG_PWR     3'h2
`define DPF_REG_CTRL    3'h3
`define DPF_ADR_A       3'h0
`define DPF_ADR_B       3'h2
`define DPF_ADR_BOTH    3'h4
`define DPF_CMD_CFG     3'h1
`define DPF_CMD_CLEAR   3'h4
`define DPF_CMD_LOAD    3'h5
`define DPF_BIT_PU_A    0
`define DPF_BIT_PU_B    2
`define DPF_BIT_TSD     5
`define DPF_BIT_OC_A    7
`define DPF_BIT_OC_B    9
`define DPF_BIT_TSD_EN  3
`define DPF_BIT_CLAMP   2
`define DPF_BIT_CLR_SEL 1
`define DPF_BIT_SDO_DIS 0
`define DPF_BIPOLAR_MIN 3'h3
`define DPF_RST_CLAMP   1'b1

`endif

//--- src/dpf_pkg.sv
// types shared by the power and fault block
// assumes: nothing beyond the map header
package dpf_pkg;
	typedef logic [23:0] dpf_word_t;
	typedef logic [15:0] dpf_data_t;
	typedef logic [2:0]  dpf_range_t;
	typedef enum logic [1:0] {
		dpf_clr_zero_v,
		dpf_clr_midscale,
		dpf_clr_neg_full
	} dpf_clr_lvl_e;
endpackage : dpf_pkg

//--- src/dpf_sync2.sv
// two flip-flop level synchroniser, one lane per bit
// assumes: inputs are levels held for at least two clk cycles
`timescale 1ns/100ps
`default_nettype none
module dpf_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : dpf_sync2
`default_nettype wire

//--- src/dpf_link.sv
// serial link end: shifts frames in on the falling link clock edge
// assumes: host frames with sync_n low, 24 bits msb first
`timescale 1ns/100ps
`default_nettype none
`include "dpf_map.svh"
module dpf_link
	import dpf_pkg::*;
(
	input  wire logic      sclk,
	input  wire logic      rst_n,
	input  wire logic      sync_n,
	input  wire logic      sdin,
	input  wire dpf_word_t rb_word,
	input  wire logic      rb_tgl,
	output var  dpf_word_t frame_word,
	output var  logic      frame_tgl,
	output var  logic      sdo
);
	logic [4:0] bit_cnt_reg;
	dpf_word_t  shift_reg;
	dpf_word_t  out_reg;
	logic       rb_meta_reg;
	logic       rb_sync_reg;
	logic       rb_seen_reg;

	// ======================================
	// frame capture
	always_ff @(negedge sclk or posedge sync_n) begin
		if (sync_n)
			bit_cnt_reg <= '0;
		else if (bit_cnt_reg != `DPF_FRAME_BITS)
			bit_cnt_reg <= bit_cnt_reg + 5'h1;
	end

	always_ff @(negedge sclk) begin
		shift_reg <= {shift_reg[22:0], sdin};
	end

	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			frame_word <= '0;
			frame_tgl  <= 1'b0;
		end else if (!sync_n && bit_cnt_reg == `DPF_FRAME_LAST) begin
			frame_word <= {shift_reg[22:0], sdin};
			frame_tgl  <= ~frame_tgl;
		end
	end

	// ======================================
	// readback shift out
	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			rb_meta_reg <= 1'b0;
			rb_sync_reg <= 1'b0;
		end else begin
			rb_meta_reg <= rb_tgl;
			rb_sync_reg <= rb_meta_reg;
		end
	end

	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			out_reg     <= '0;
			rb_seen_reg <= 1'b0;
		end else if (bit_cnt_reg == `DPF_RB_LOAD_AT && rb_sync_reg != rb_seen_reg) begin
			out_reg     <= {rb_word[20:0], 3'h0};
			rb_seen_reg <= rb_sync_reg;
		end else begin
			out_reg <= {out_reg[22:0], 1'b0};
		end
	end

	assign sdo = out_reg[23];
endmodule : dpf_link
`default_nettype wire

//--- src/dpf_power_fault_ctrl.sv
// channel power and fault supervision for a dual output converter
// assumes: host on the serial link, fault sensors as async level pins
`timescale 1ns/100ps
`default_nettype none
`include "dpf_map.svh"

// What this block does
// - clear code: zero volts, or midscale/negative full
// - register select 010 reaches power control
// - bit 0 powers channel a, default off
// - bit 2 powers channel b, default off
// - clamp off: overcurrent powers channel down
// - overtemperature powers both down, sets flag
// - bit 7 shows channel a overcurrent
// - bit 9 shows channel b overcurrent
// - clamp on: flag follows short, channel stays
// - outputs grounded until first data word
// - channels independent, start powered down, grounded
// - thermal shutdown only when armed, reset off
// - current clamp enabled after reset
module dpf_power_fault_ctrl
	import dpf_pkg::*;
(
	input  wire logic   clk_sys,
	input  wire logic   rst_n,
	input  wire logic   sclk,
	input  wire logic   sync_n,
	input  wire logic   sdin,
	input  wire logic   oc_a_in,
	input  wire logic   oc_b_in,
	input  wire logic   overtemp_in,
	output var  logic   sdo,
	output var  logic   amp_output_gate_a,
	output var  logic   amp_output_gate_b,
	output var  logic   output_ground_switch_a,
	output var  logic   output_ground_switch_b,
	output var  dpf_clr_lvl_e clr_level_a,
	output var  dpf_clr_lvl_e clr_level_b,
	output var  logic   clear_strobe,
	output var  logic   load_outputs_strobe,
	output var  logic   thermal_shutdown_flag,
	output var  logic   chan_a_overcurrent_flag,
	output var  logic   chan_b_overcurrent_flag
);
	dpf_word_t  frame_word;
	logic       frame_tgl;
	dpf_word_t  rb_word_reg;
	logic       rb_tgl_reg;
	logic [3:0] sync_q;
	logic       fr_tgl_s;
	logic       oc_a_s;
	logic       oc_b_s;
	logic       ot_s;
	logic       fr_seen_reg;
	logic       frame_pulse;

	logic       fr_rw;
	logic       fr_zero;
	logic [2:0] fr_reg;
	logic [2:0] fr_adr;
	dpf_data_t  fr_data;
	logic       wr_ok;
	logic       wr_pwr;
	logic       wr_dac;
	logic       wr_rng;
	logic       wr_cfg;
	logic       hit_a;
	logic       hit_b;
	logic       tsd_trip;
	logic       stop_a;
	logic       stop_b;

	logic       chan_a_power_on_reg;
	logic       chan_b_power_on_reg;
	logic       clamp_en_reg;
	logic       thermal_shutdown_arm_reg;
	logic       clear_code_select_reg;
	logic       sdo_dis_reg;
	dpf_range_t range_a_reg;
	dpf_range_t range_b_reg;
	logic       seen_a_reg;
	logic       seen_b_reg;
	dpf_data_t  pwr_view;
	dpf_data_t  rd_data;

	// ======================================
	// link and pin crossing
	dpf_link u_link (
		.sclk       (sclk),
		.rst_n      (rst_n),
		.sync_n     (sync_n),
		.sdin       (sdin),
		.rb_word    (rb_word_reg),
		.rb_tgl     (rb_tgl_reg),
		.frame_word (frame_word),
		.frame_tgl  (frame_tgl),
		.sdo        (sdo)
	);

	dpf_sync2 #(.W(4)) u_sync (
		.clk   (clk_sys),
		.rst_n (rst_n),
		.d     ({overtemp_in, oc_b_in, oc_a_in, frame_tgl}),
		.q     (sync_q)
	);

	assign fr_tgl_s = sync_q[0];
	assign oc_a_s   = sync_q[1];
	assign oc_b_s   = sync_q[2];
	assign ot_s     = sync_q[3];

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			fr_seen_reg <= 1'b0;
		else
			fr_seen_reg <= fr_tgl_s;
	end

	assign frame_pulse = fr_tgl_s != fr_seen_reg;

	// ======================================
	// frame decode
	assign fr_rw   = frame_word[`DPF_BIT_RW];
	assign fr_zero = frame_word[`DPF_BIT_ZERO];
	assign fr_reg  = frame_word[`DPF_REG_HI:`DPF_REG_LO];
	assign fr_adr  = frame_word[`DPF_ADR_HI:`DPF_ADR_LO];
	assign fr_data = frame_word[`DPF_DATA_HI:0];

	assign wr_ok  = frame_pulse && !fr_rw && !fr_zero;
	assign wr_pwr = wr_ok && fr_reg == `DPF_REG_PWR;
	assign wr_dac = wr_ok && fr_reg == `DPF_REG_DAC;
	assign wr_rng = wr_ok && fr_reg == `DPF_REG_RANGE;
	assign wr_cfg = wr_ok && fr_reg == `DPF_REG_CTRL && fr_adr == `DPF_CMD_CFG;
	assign hit_a  = fr_adr == `DPF_ADR_A || fr_adr == `DPF_ADR_BOTH;
	assign hit_b  = fr_adr == `DPF_ADR_B || fr_adr == `DPF_ADR_BOTH;

	assign tsd_trip = thermal_shutdown_arm_reg && ot_s;
	assign stop_a   = tsd_trip || (!clamp_en_reg && oc_a_s);
	assign stop_b   = tsd_trip || (!clamp_en_reg && oc_b_s);

	// ======================================
	// control and range registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			clamp_en_reg             <= `DPF_RST_CLAMP;
			thermal_shutdown_arm_reg <= 1'b0;
			clear_code_select_reg    <= 1'b0;
			sdo_dis_reg              <= 1'b0;
		end else if (wr_cfg) begin
			clamp_en_reg             <= fr_data[`DPF_BIT_CLAMP];
			thermal_shutdown_arm_reg <= fr_data[`DPF_BIT_TSD_EN];
			clear_code_select_reg    <= fr_data[`DPF_BIT_CLR_SEL];
			sdo_dis_reg              <= fr_data[`DPF_BIT_SDO_DIS];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			range_a_reg <= '0;
			range_b_reg <= '0;
		end else if (wr_rng) begin
			if (hit_a)
				range_a_reg <= fr_data[`DPF_RANGE_HI:0];
			if (hit_b)
				range_b_reg <= fr_data[`DPF_RANGE_HI:0];
		end
	end

	// ======================================
	// channel power, faults win over a host write
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			chan_a_power_on_reg <= 1'b0;
			chan_b_power_on_reg <= 1'b0;
		end else begin
			if (stop_a)
				chan_a_power_on_reg <= 1'b0;
			else if (wr_pwr)
				chan_a_power_on_reg <= fr_data[`DPF_BIT_PU_A];
			if (stop_b)
				chan_b_power_on_reg <= 1'b0;
			else if (wr_pwr)
				chan_b_power_on_reg <= fr_data[`DPF_BIT_PU_B];
		end
	end

	// ======================================
	// overcurrent flags follow the sensed condition, thermal flag follows the armed trip
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			chan_a_overcurrent_flag <= 1'b0;
			chan_b_overcurrent_flag <= 1'b0;
			thermal_shutdown_flag   <= 1'b0;
		end else begin
			chan_a_overcurrent_flag <= oc_a_s;
			chan_b_overcurrent_flag <= oc_b_s;
			thermal_shutdown_flag   <= tsd_trip;
		end
	end

	// ======================================
	// output gating
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			seen_a_reg <= 1'b0;
			seen_b_reg <= 1'b0;
		end else if (wr_dac) begin
			if (hit_a)
				seen_a_reg <= 1'b1;
			if (hit_b)
				seen_b_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			amp_output_gate_a      <= 1'b0;
			amp_output_gate_b      <= 1'b0;
			output_ground_switch_a <= 1'b1;
			output_ground_switch_b <= 1'b1;
		end else begin
			amp_output_gate_a      <= chan_a_power_on_reg && seen_a_reg;
			amp_output_gate_b      <= chan_b_power_on_reg && seen_b_reg;
			output_ground_switch_a <= !(chan_a_power_on_reg && seen_a_reg);
			output_ground_switch_b <= !(chan_b_power_on_reg && seen_b_reg);
		end
	end

	// ======================================
	// clear code and command strobes
	function automatic dpf_clr_lvl_e clr_of(input dpf_range_t rng, input logic sel);
		if (!sel)
			clr_of = dpf_clr_zero_v;
		else if (rng >= `DPF_BIPOLAR_MIN)
			clr_of = dpf_clr_neg_full;
		else
			clr_of = dpf_clr_midscale;
	endfunction : clr_of

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			clr_level_a         <= dpf_clr_zero_v;
			clr_level_b         <= dpf_clr_zero_v;
			clear_strobe        <= 1'b0;
			load_outputs_strobe <= 1'b0;
		end else begin
			clr_level_a         <= clr_of(range_a_reg, clear_code_select_reg);
			clr_level_b         <= clr_of(range_b_reg, clear_code_select_reg);
			clear_strobe        <= wr_ok && fr_reg == `DPF_REG_CTRL && fr_adr == `DPF_CMD_CLEAR;
			load_outputs_strobe <= wr_ok && fr_reg == `DPF_REG_CTRL && fr_adr == `DPF_CMD_LOAD;
		end
	end

	// ======================================
	// readback
	always_comb begin
		pwr_view                = '0;
		pwr_view[`DPF_BIT_PU_A] = chan_a_power_on_reg;
		pwr_view[`DPF_BIT_PU_B] = chan_b_power_on_reg;
		pwr_view[`DPF_BIT_TSD]  = thermal_shutdown_flag;
		pwr_view[`DPF_BIT_OC_A] = chan_a_overcurrent_flag;
		pwr_view[`DPF_BIT_OC_B] = chan_b_overcurrent_flag;
	end

	always_comb begin
		rd_data = '0;
		case (fr_reg)
			`DPF_REG_PWR: rd_data = pwr_view;
			`DPF_REG_CTRL: begin
				rd_data[`DPF_BIT_TSD_EN]  = thermal_shutdown_arm_reg;
				rd_data[`DPF_BIT_CLAMP]   = clamp_en_reg;
				rd_data[`DPF_BIT_CLR_SEL] = clear_code_select_reg;
				rd_data[`DPF_BIT_SDO_DIS] = sdo_dis_reg;
			end
			`DPF_REG_RANGE: rd_data[`DPF_RANGE_HI:0] = fr_adr == `DPF_ADR_B ? range_b_reg : range_a_reg;
			default: rd_data = '0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rb_word_reg <= '0;
			rb_tgl_reg  <= 1'b0;
		end else if (frame_pulse && fr_rw && !sdo_dis_reg) begin
			rb_word_reg <= {frame_word[23:16], rd_data};
			rb_tgl_reg  <= ~rb_tgl_reg;
		end
	end

	// ======================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_pwr_reset_off: assert property (
		!$past(rst_n) |-> !chan_a_power_on_reg && !chan_b_power_on_reg && output_ground_switch_a)
		else $error("channel not powered down after reset");
	chk_clamp_default: assert property (
		!$past(rst_n) |-> clamp_en_reg) else $error("current clamp not enabled after reset");
	chk_tsd_idle: assert property (
		!thermal_shutdown_arm_reg |=> !thermal_shutdown_flag && !$past(tsd_trip))
		else $error("thermal shutdown acted while not armed");
	chk_pu_a_write: assert property (
		wr_pwr && !stop_a |=> chan_a_power_on_reg == $past(frame_word[`DPF_BIT_PU_A]))
		else $error("channel a power bit not taken from bit 0");
	chk_pu_b_write: assert property (
		wr_pwr && !stop_b |=> chan_b_power_on_reg == $past(frame_word[`DPF_BIT_PU_B]))
		else $error("channel b power bit not taken from bit 2");
	chk_pwr_decode: assert property (
		frame_pulse && fr_reg != `DPF_REG_PWR && !stop_a |=> $stable(chan_a_power_on_reg))
		else $error("power bit changed by another register select");
	chk_oc_autodown: assert property (
		!clamp_en_reg && oc_b_s |=> !chan_b_power_on_reg ##1 !amp_output_gate_b)
		else $error("overcurrent did not power the channel down");
	chk_tsd_down: assert property (
		tsd_trip |=> thermal_shutdown_flag && !chan_a_power_on_reg && !chan_b_power_on_reg)
		else $error("thermal event did not shut both channels down");
	chk_oc_a_flag: assert property (
		oc_a_s [*2] |-> chan_a_overcurrent_flag) else $error("channel a overcurrent not flagged");
	chk_oc_b_flag: assert property (
		oc_b_s [*2] |-> chan_b_overcurrent_flag) else $error("channel b overcurrent not flagged");
	chk_clamp_keep: assert property (
		clamp_en_reg && oc_a_s && chan_a_power_on_reg && !tsd_trip && !wr_pwr
		|=> chan_a_power_on_reg && chan_a_overcurrent_flag)
		else $error("clamped short shut the channel or was not flagged");
	chk_oc_a_clear: assert property (
		!oc_a_s [*2] |-> !chan_a_overcurrent_flag) else $error("channel a overcurrent flag stuck");
	chk_gate_hold: assert property (
		!seen_a_reg |=> !amp_output_gate_a && output_ground_switch_a)
		else $error("output released before a data word");
	chk_no_restart: assert property (
		!chan_a_power_on_reg && !wr_pwr |=> !chan_a_power_on_reg)
		else $error("channel restarted without a host write");
	chk_clr_level: assert property (
		!clear_code_select_reg && !wr_cfg |=> clr_level_a == dpf_clr_zero_v)
		else $error("clear level not zero volts when select is 0");

	cov_autodown: cover property (chan_a_power_on_reg && !clamp_en_reg && oc_a_s);
	cov_tsd_trip: cover property (tsd_trip && chan_b_power_on_reg);
	cov_clear: cover property (clear_strobe && clr_level_b == dpf_clr_neg_full);
	cov_readback: cover property ($changed(rb_tgl_reg) && rb_word_reg[`DPF_BIT_OC_A]);
endmodule : dpf_power_fault_ctrl
`default_nettype wire

//--- verif/dpf_host_model.sv
// host side of the serial link: frames words msb first, captures readback
// assumes: called from the bench between frames, frames spaced >= 500 ns
`timescale 1ns/100ps
`default_nettype none
module dpf_host_model
	import dpf_pkg::*;
(
	output var  logic      sclk,
	output var  logic      sync_n,
	output var  logic      sdin,
	input  wire logic      sdo,
	output var  dpf_data_t rd_data,
	output var  logic      rd_tgl
);
	// ==========================================================
	// idle levels: link clock stands still low between frames
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		sdin = 1'b0;
		rd_data = '0;
		rd_tgl = 1'b0;
	end
	// ==========================================================
	// one 24 bit frame at a 6 ns link period
	task automatic xfer(input dpf_word_t w, input logic grab);
		dpf_data_t cap;
		cap = '0;
		sync_n = 1'b0;
		for (int k = 1; k <= 24; k++) begin
			#1 sdin = w[24-k];
			#2 sclk = 1'b1;
			if (k >= 9) cap[24-k] = sdo;
			#3 sclk = 1'b0;
		end
		#3 sync_n = 1'b1;
		// released data line shows the inverse of the last bit
		sdin = ~w[0];
		if (grab) begin
			rd_data = cap;
			rd_tgl = ~rd_tgl;
		end
	endtask : xfer
endmodule : dpf_host_model
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench of the power and fault block
// assumes: host model drives the link, bench drives fault pins
`timescale 1ns/100ps
`default_nettype none
`include "dpf_map.svh"
module tb_top
	import dpf_pkg::*;
;
	logic         clk_sys, rst_n, sclk, sync_n, sdin, sdo, rd_tgl;
	logic         oc_a_in, oc_b_in, overtemp_in, clear_strobe, load_outputs_strobe;
	logic         amp_output_gate_a, amp_output_gate_b;
	logic         output_ground_switch_a, output_ground_switch_b;
	logic         thermal_shutdown_flag, chan_a_overcurrent_flag, chan_b_overcurrent_flag;
	dpf_clr_lvl_e clr_level_a, clr_level_b;
	dpf_data_t    rd_data;
	dpf_data_t    exp_q[$];
	int           n_mismatch, n_tests, n_clr, n_load, cyc;
	integer       seed = 32'h1209;

	dpf_power_fault_ctrl dpf_power_fault_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.sclk(sclk), .sync_n(sync_n), .sdin(sdin), .oc_a_in(oc_a_in), .oc_b_in(oc_b_in),
		.overtemp_in(overtemp_in), .sdo(sdo), .amp_output_gate_a(amp_output_gate_a),
		.amp_output_gate_b(amp_output_gate_b), .output_ground_switch_a(output_ground_switch_a),
		.output_ground_switch_b(output_ground_switch_b), .clr_level_a(clr_level_a),
		.clr_level_b(clr_level_b), .clear_strobe(clear_strobe),
		.load_outputs_strobe(load_outputs_strobe), .thermal_shutdown_flag(thermal_shutdown_flag),
		.chan_a_overcurrent_flag(chan_a_overcurrent_flag),
		.chan_b_overcurrent_flag(chan_b_overcurrent_flag));
	dpf_host_model dpf_host_model_i (.sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo),
		.rd_data(rd_data), .rd_tgl(rd_tgl));

	// ==========================================================
	// clock, timeout, strobe counters
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (clear_strobe === 1'b1) n_clr++;
		if (load_outputs_strobe === 1'b1) n_load++;
		if (cyc == 5000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// ==========================================================
	// helpers
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_clk
	function automatic dpf_data_t rnd();
		rnd = dpf_data_t'($random(seed)) & 16'hf95a;
	endfunction : rnd
	task automatic wr(input logic [2:0] rs, input logic [2:0] ad, input dpf_data_t d);
		dpf_host_model_i.xfer({1'b0, 1'b0, rs, ad, d}, 1'b0);
		wait_clk(8);
	endtask : wr
	task automatic rd(input logic [2:0] rs, input logic [2:0] ad, input dpf_data_t e);
		dpf_host_model_i.xfer({1'b1, 1'b0, rs, ad, 16'h0000}, 1'b0);
		wait_clk(8);
		exp_q.push_back(e);
		dpf_host_model_i.xfer({1'b0, 1'b0, `DPF_REG_CTRL, `DPF_ADR_A, 16'h0000}, 1'b1);
		wait_clk(8);
	endtask : rd
	task automatic gates(input logic ga, input logic gb);
		chk({12'h000, amp_output_gate_a, amp_output_gate_b, output_ground_switch_a,
			output_ground_switch_b}, {12'h000, ga, gb, ~ga, ~gb}, "gates");
	endtask : gates
	// ==========================================================
	// readback watcher takes the oldest note
	always @(rd_tgl) begin
		if ($time > 0) begin
			if (exp_q.size() == 0) chk(16'h0001, 16'h0000, "unexpected readback");
			else chk(rd_data, exp_q.pop_front(), "readback");
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		oc_a_in = 1'b0;
		oc_b_in = 1'b0;
		overtemp_in = 1'b0;
		wait_clk(10);
		rst_n = 1'b1;
		wait_clk(2);
		gates(1'b0, 1'b0);
		rd(`DPF_REG_PWR, `DPF_ADR_A, 16'h0000);
		rd(`DPF_REG_CTRL, `DPF_CMD_CFG, 16'h0004);
		wr(`DPF_REG_PWR, `DPF_ADR_A, rnd() | 16'h0001);
		gates(1'b0, 1'b0);
		rd(`DPF_REG_PWR, `DPF_ADR_A, 16'h0001);
		wr(`DPF_REG_DAC, `DPF_ADR_A, dpf_data_t'($random(seed)));
		gates(1'b1, 1'b0);
		wr(`DPF_REG_PWR, `DPF_ADR_A, rnd() | 16'h0005);
		gates(1'b1, 1'b0);
		wr(`DPF_REG_DAC, `DPF_ADR_BOTH, dpf_data_t'($random(seed)));
		gates(1'b1, 1'b1);
		oc_a_in = 1'b1;
		wait_clk(6);
		chk({15'h0, chan_a_overcurrent_flag}, 16'h0001, "oc a flag");
		gates(1'b1, 1'b1);
		rd(`DPF_REG_PWR, `DPF_ADR_A, 16'h0085);
		oc_a_in = 1'b0;
		wait_clk(6);
		chk({15'h0, chan_a_overcurrent_flag}, 16'h0000, "oc a clears");
		wr(`DPF_REG_CTRL, `DPF_CMD_CFG, 16'h0000);
		oc_b_in = 1'b1;
		wait_clk(6);
		chk({15'h0, chan_b_overcurrent_flag}, 16'h0001, "oc b flag");
		gates(1'b1, 1'b0);
		rd(`DPF_REG_PWR, `DPF_ADR_A, 16'h0201);
		oc_b_in = 1'b0;
		wait_clk(6);
		gates(1'b1, 1'b0);
		rd(`DPF_REG_PWR, `DPF_ADR_A, 16'h0001);
		wr(`DPF_REG_PWR, `DPF_ADR_A, rnd() | 16'h0005);
		gates(1'b1, 1'b1);
		overtemp_in = 1'b1;
		wait_clk(6);
		chk({15'h0, thermal_shutdown_flag}, 16'h0000, "thermal unarmed");
		gates(1'b1, 1'b1);
		wr(`DPF_REG_CTRL, `DPF_CMD_CFG, 16'h0008);
		chk({15'h0, thermal_shutdown_flag}, 16'h0001, "thermal flag");
		gates(1'b0, 1'b0);
		rd(`DPF_REG_PWR, `DPF_ADR_A, 16'h0020);
		overtemp_in = 1'b0;
		wait_clk(6);
		wr(`DPF_REG_CTRL, `DPF_CMD_CFG, 16'h0002);
		wr(`DPF_REG_RANGE, `DPF_ADR_A, 16'h0000);
		wr(`DPF_REG_RANGE, `DPF_ADR_B, 16'h0004);
		rd(`DPF_REG_RANGE, `DPF_ADR_B, 16'h0004);
		wr(`DPF_REG_CTRL, `DPF_CMD_CLEAR, 16'h0000);
		chk(16'(n_clr), 16'h0001, "clear strobe");
		chk({14'h0, clr_level_a}, {14'h0, dpf_clr_midscale}, "clr a sel1");
		chk({14'h0, clr_level_b}, {14'h0, dpf_clr_neg_full}, "clr b sel1");
		wr(`DPF_REG_CTRL, `DPF_CMD_CFG, 16'h0000);
		wr(`DPF_REG_CTRL, `DPF_CMD_CLEAR, 16'h0000);
		chk({12'h0, clr_level_a, clr_level_b}, {12'h0, dpf_clr_zero_v, dpf_clr_zero_v}, "clr0");
		wr(`DPF_REG_PWR, `DPF_ADR_A, rnd() | 16'h0001);
		wait_clk(100);
		wr(`DPF_REG_CTRL, `DPF_CMD_LOAD, 16'h0000);
		chk(16'(n_load), 16'h0001, "load strobe");
		gates(1'b1, 1'b0);
		dpf_host_model_i.xfer({1'b0, 1'b1, `DPF_REG_PWR, `DPF_ADR_A, 16'h0005}, 1'b0);
		wait_clk(8);
		wr(`DPF_REG_CTRL, `DPF_CMD_CFG, 16'h0005);
		rd(`DPF_REG_PWR, `DPF_ADR_A, 16'h0000);
		wr(`DPF_REG_CTRL, `DPF_CMD_CFG, 16'h0004);
		rd(`DPF_REG_PWR, `DPF_ADR_A, 16'h0001);
		chk(16'(exp_q.size()), 16'h0000, "readbacks seen");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
